// [core/imfu_defs.vh]
`ifndef IMFU_DEFS_VH
`define IMFU_DEFS_VH

// register addresses (printed offsets are word indexes: byte = 4 * index)
`define IMFU_IDX_TFLAGS      8'h38
`define IMFU_IDX_TENABLES    8'h39
`define IMFU_IDX_PFLAGS      8'h3A
`define IMFU_IDX_PENABLES    8'h3B
`define IMFU_IDX_CORECTL     8'h3C
`define IMFU_IDX_STATE       8'h3D
`define IMFU_IDX_VECTOR      8'h3E

// bit positions
`define IMFU_BIT_PIN_B       7
`define IMFU_BIT_PIN_A       6
`define IMFU_BIT_WIDE_OVF    7
`define IMFU_BIT_MATCH       6
`define IMFU_BIT_CAPTURE     3
`define IMFU_BIT_NARROW_OVF  1
`define IMFU_BIT_GLOBAL_EN   7

// writable-bit masks; all other bits are reserved and read zero
`define IMFU_PIN_MASK        8'hC0
`define IMFU_TIMER_MASK      8'hCA
`define IMFU_CORECTL_MASK    8'h0F

// sense control encodings
`define IMFU_SENSE_LOW       2'b00
`define IMFU_SENSE_RSVD      2'b01
`define IMFU_SENSE_FALL      2'b10
`define IMFU_SENSE_RISE      2'b11

// vector addresses
`define IMFU_VEC_NONE        4'h0
`define IMFU_VEC_PIN_A       4'h1
`define IMFU_VEC_PIN_B       4'h2
`define IMFU_VEC_CAPTURE     4'h3
`define IMFU_VEC_MATCH       4'h4
`define IMFU_VEC_WIDE_OVF    4'h5
`define IMFU_VEC_NARROW_OVF  4'h6

`define IMFU_RESET_BYTE      8'h00

`endif

// [core/imfu_irq_mask_flag_unit.v]
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`include "imfu_defs.vh"

module imfu_irq_mask_flag_unit (
    // clock and reset
    input  wire        ref_clk,
    input  wire        reset_n,
    // avalon-mm slave
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // external pins (asynchronous)
    input  wire        pinA,
    input  wire        pinB,
    // timer event pulses and the pwm mode level, same clock
    input  wire        wideOverflowEvt,
    input  wire        wideTurnaroundEvt,
    input  wire        pwmMode,
    input  wire        matchEvt,
    input  wire        captureEvt,
    input  wire        narrowOverflowEvt,
    // cpu sequencer
    input  wire        irqAck,
    input  wire        returnFromIrq,
    input  wire        globalSet,
    input  wire        globalClear,
    output reg         irqReq,
    output reg  [3:0]  irqVector,
    output reg         globalEnable
);

    // overview of the unit
    //   - two external pins, each with its own sense field
    //   - five timer event inputs feeding four flags
    //   - a byte-wide register window on the bus
    //   - one registered request and vector to the core
    //   - one global enable bit owned by this unit
    // everything runs on ref_clk; only the pins are foreign
    // to that clock, so only they pass a synchroniser
    // timer pulses come from logic on the same clock and
    // are used as they arrive, with no extra delay
    // a flag is a plain sticky bit: set by hardware,
    // cleared by the core on entry or by a written one
    // the request output lags the flags by one cycle,
    // which keeps every top-level output on a flip-flop
    // pin synchronisers; first stage feeds only the second
    reg [1:0] pinAMeta_q, pinASync_q, pinBMeta_q, pinBSync_q;
    reg       pinAPrev_q, pinBPrev_q;
    // software state
    reg [7:0] pinEnables_q;
    reg [7:0] timerEnables_q;
    reg [3:0] coreCtl_q;
    reg [1:0] pinFlags_q;    // [1]=pin B, [0]=pin A
    reg [3:0] timerFlags_q;  // [3]=wide ovf, [2]=match, [1]=capture, [0]=narrow ovf
    reg       busy_q;

    wire [1:0] senseA = coreCtl_q[1:0];
    wire [1:0] senseB = coreCtl_q[3:2];
    wire       pinANow = pinASync_q[0];
    wire       pinBNow = pinBSync_q[0];

    // sense field per pin, two bits each
    //   00: low level, no flag, request while low
    //   01: reserved, sets no flag; a flag already set still requests
    //   10: falling edge latches the flag
    //   11: rising edge latches the flag
    // the edge is taken between the second synchroniser
    // stage and a one-bit history register, so a pin
    // change shows up three edges later as a flag
    // limitation: a pulse on the pin shorter than one
    // clock period may be missed; no glitch catcher here
    // the history register resets low while idle pins sit
    // high; the false rising edge after reset is harmless
    // because the sense field resets to level mode
    // software should clear stale flags after it changes
    // a sense field from an edge mode to the reserved mode
    function edgeHit;
        input [1:0] sense;
        input       now;
        input       prev;
        begin
            case (sense)
                `IMFU_SENSE_RISE: edgeHit = now & ~prev;
                `IMFU_SENSE_FALL: edgeHit = ~now & prev;
                default:          edgeHit = 1'b0;
            endcase
        end
    endfunction

    wire levelA = (senseA == `IMFU_SENSE_LOW);
    wire levelB = (senseB == `IMFU_SENSE_LOW);
    wire edgeA  = edgeHit(senseA, pinANow, pinAPrev_q);
    wire edgeB  = edgeHit(senseB, pinBNow, pinBPrev_q);

    // bus timing, one access:
    //   edge 0: read or write sampled with the unit idle
    //   cycle 1: waitrequest low, read data on the bus
    //   edge 1: write lands, master takes read data
    // busy_q marks cycle 1 so the still-held request is
    // not taken a second time at edge 1
    // trade-off: one wait state on every access buys a
    // fully registered read path and waitrequest
    // only the low byte lane carries a register; the
    // other lanes read zero and are ignored on writes
    // a write with lane zero disabled changes nothing
    // addresses are byte addresses, one word per register
    // unmapped words read zero and drop writes
    // bus decode; one wait cycle so every access answers on the second edge
    wire       access  = (avs_read | avs_write) & ~busy_q;
    wire       wrTake  = avs_write & busy_q & avs_byteenable[0];
    wire [7:0] wByte   = avs_writedata[7:0];
    wire       wrPF    = wrTake && avs_address == (`IMFU_IDX_PFLAGS << 2);
    wire       wrTF    = wrTake && avs_address == (`IMFU_IDX_TFLAGS << 2);
    wire       wrPE    = wrTake && avs_address == (`IMFU_IDX_PENABLES << 2);
    wire       wrTE    = wrTake && avs_address == (`IMFU_IDX_TENABLES << 2);
    wire       wrCC    = wrTake && avs_address == (`IMFU_IDX_CORECTL << 2);
    wire       wrST    = wrTake && avs_address == (`IMFU_IDX_STATE << 2);

    // request terms per source
    // each source is pending when its own enable is set
    // and its flag is set; pins in level mode use the
    // synchronised pin level instead of a flag
    // the global enable is applied later, at the
    // request register, so the vector status word still
    // shows the winning source while interrupts are off
    // this lets software poll pending work with the
    // global enable cleared
    // the timer enable register is stored already masked,
    // so reserved enable bits can never raise a request
    // pending requests, gated by their own enables
    wire reqPinA = pinEnables_q[`IMFU_BIT_PIN_A] &
                   (levelA ? ~pinANow : pinFlags_q[0]);
    wire reqPinB = pinEnables_q[`IMFU_BIT_PIN_B] &
                   (levelB ? ~pinBNow : pinFlags_q[1]);
    wire reqCap  = timerEnables_q[`IMFU_BIT_CAPTURE] & timerFlags_q[1];
    wire reqMat  = timerEnables_q[`IMFU_BIT_MATCH] & timerFlags_q[2];
    wire reqWide = timerEnables_q[`IMFU_BIT_WIDE_OVF] & timerFlags_q[3];
    wire reqNar  = timerEnables_q[`IMFU_BIT_NARROW_OVF] & timerFlags_q[0];

    // priority order, highest first:
    //   pin A, pin B, capture, match,
    //   wide overflow, narrow overflow
    // a lower source that loses keeps its flag and is
    // presented again once the winner has been entered
    // the chain is a plain if ladder on purpose: six
    // inputs are cheap and the order stays readable
    // hazard: the vector may change from one cycle to
    // the next while a new source arrives; the core must
    // take the vector shown in the cycle it acknowledges
    // fixed priority, lowest vector first
    reg [3:0] vec_d;
    always @* begin
        if (reqPinA)
            vec_d = `IMFU_VEC_PIN_A;
        else if (reqPinB)
            vec_d = `IMFU_VEC_PIN_B;
        else if (reqCap)
            vec_d = `IMFU_VEC_CAPTURE;
        else if (reqMat)
            vec_d = `IMFU_VEC_MATCH;
        else if (reqWide)
            vec_d = `IMFU_VEC_WIDE_OVF;
        else if (reqNar)
            vec_d = `IMFU_VEC_NARROW_OVF;
        else
            vec_d = `IMFU_VEC_NONE;
    end

    // the acked vector is the one presented in the ack cycle
    wire ackTake = irqAck & irqReq;
    wire [3:0] ackVec = ackTake ? irqVector : `IMFU_VEC_NONE;

    // flag update rules
    // an event and a clear in the same cycle leave the
    // flag set, so no event is ever lost to a clear
    // clears come from two places:
    //   - a one written to the flag bit on the bus
    //   - the core acknowledging that flag's vector
    // a written zero leaves the flag as it is
    // in pwm mode the plain overflow pulse is ignored and
    // only the turnaround at zero sets the wide flag
    // pin flags in level mode are forced to zero so a
    // stale edge flag cannot survive a mode change
    // reads return these next values, so a flag set in
    // the same cycle as the read is already visible
    // flag next values: set wins over any clear in the same cycle
    reg [1:0] pinFlags_d;
    reg [3:0] timerFlags_d;
    reg [3:0] tSet;
    reg [3:0] tClr;
    reg [1:0] pClr;
    always @* begin
        tSet = {(pwmMode ? wideTurnaroundEvt : wideOverflowEvt),
                matchEvt,
                captureEvt,
                narrowOverflowEvt};
        tClr = {(wrTF & wByte[`IMFU_BIT_WIDE_OVF]) | (ackVec == `IMFU_VEC_WIDE_OVF),
                (wrTF & wByte[`IMFU_BIT_MATCH]) | (ackVec == `IMFU_VEC_MATCH),
                (wrTF & wByte[`IMFU_BIT_CAPTURE]) | (ackVec == `IMFU_VEC_CAPTURE),
                (wrTF & wByte[`IMFU_BIT_NARROW_OVF]) | (ackVec == `IMFU_VEC_NARROW_OVF)};
        timerFlags_d = tSet | (timerFlags_q & ~tClr);
        pClr = {(wrPF & wByte[`IMFU_BIT_PIN_B]) | (ackVec == `IMFU_VEC_PIN_B),
                (wrPF & wByte[`IMFU_BIT_PIN_A]) | (ackVec == `IMFU_VEC_PIN_A)};
        pinFlags_d = {edgeB, edgeA} | (pinFlags_q & ~pClr);
        // level sensing keeps no flag at all
        if (levelA)
            pinFlags_d[0] = 1'b0;
        if (levelB)
            pinFlags_d[1] = 1'b0;
    end

    // synchroniser notes
    // each pin passes a meta stage and a sync stage;
    // only the sync stage output is read by logic
    // the upper bit of each stage is a constant zero
    // and is kept only for a uniform width
    // reset clears both stages and the history bit;
    // nothing here is driven by logic on reset
    // the history bit is the previous sync value and
    // feeds only the edge function
    // latency from pin to flag is three clock edges
    // pin synchronisers and edge history
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pinAMeta_q <= 2'b00;
            pinASync_q <= 2'b00;
            pinBMeta_q <= 2'b00;
            pinBSync_q <= 2'b00;
            pinAPrev_q <= 1'b0;
            pinBPrev_q <= 1'b0;
        end else begin
            pinAMeta_q <= {1'b0, pinA};
            pinASync_q <= pinAMeta_q;
            pinBMeta_q <= {1'b0, pinB};
            pinBSync_q <= pinBMeta_q;
            pinAPrev_q <= pinANow;
            pinBPrev_q <= pinBNow;
        end
    end

    // register file and flags
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pinEnables_q   <= `IMFU_RESET_BYTE;
            timerEnables_q <= `IMFU_RESET_BYTE;
            coreCtl_q      <= 4'h0;
            pinFlags_q     <= 2'b00;
            timerFlags_q   <= 4'h0;
        end else begin
            pinFlags_q   <= pinFlags_d;
            timerFlags_q <= timerFlags_d;
            if (wrPE)
                pinEnables_q <= wByte & `IMFU_PIN_MASK;
            if (wrTE)
                timerEnables_q <= wByte & `IMFU_TIMER_MASK;
            if (wrCC)
                coreCtl_q <= wByte[3:0];
        end
    end

    // global enable notes
    // entry to any handler clears the bit so handlers
    // do not nest unless software sets it again
    // a return from a handler sets it once more
    // the core may also set or clear it directly, and
    // software may write it through the state register
    // order of precedence, strongest first:
    //   entry or clear, return or set, bus write
    // entry winning over return avoids a window in which
    // a second handler could start with interrupts on
    // global enable: entry clears, return sets; entry wins when both occur
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            globalEnable <= 1'b0;
        end else if (ackTake | globalClear) begin
            globalEnable <= 1'b0;
        end else if (returnFromIrq | globalSet) begin
            globalEnable <= 1'b1;
        end else if (wrST) begin
            globalEnable <= wByte[`IMFU_BIT_GLOBAL_EN];
        end
    end

    // request to the core: all three terms must hold at once
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqReq    <= 1'b0;
            irqVector <= `IMFU_VEC_NONE;
        end else begin
            irqReq    <= globalEnable & ~ackTake & (vec_d != `IMFU_VEC_NONE);
            irqVector <= vec_d;
        end
    end

    // read path notes
    // read data is captured at the edge that takes the
    // access and stands for exactly one cycle, in the
    // cycle waitrequest is low; it is zero otherwise
    // reserved bits are zero by construction of each read word,
    // except the two enable words, which read the masked stored value
    // the vector status word is read only and shows the
    // request bit above the four vector bits
    // the state word shows the global enable in bit 7
    // bus handshake; reads capture the current state in the wait cycle
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q          <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            busy_q          <= access;
            avs_waitrequest <= ~access;
            if (access) begin
                case (avs_address)
                    (`IMFU_IDX_PFLAGS << 2):
                        avs_readdata <= {24'h00_0000, pinFlags_d, 6'h00};
                    (`IMFU_IDX_TFLAGS << 2):
                        avs_readdata <= {24'h00_0000, timerFlags_d[3:2], 2'b00,
                                         timerFlags_d[1], 1'b0, timerFlags_d[0],
                                         1'b0};
                    (`IMFU_IDX_PENABLES << 2):
                        avs_readdata <= {24'h00_0000, pinEnables_q};
                    (`IMFU_IDX_TENABLES << 2):
                        avs_readdata <= {24'h00_0000, timerEnables_q};
                    (`IMFU_IDX_CORECTL << 2):
                        avs_readdata <= {28'h000_0000, coreCtl_q};
                    (`IMFU_IDX_STATE << 2):
                        avs_readdata <= {24'h00_0000, globalEnable, 7'h00};
                    (`IMFU_IDX_VECTOR << 2):
                        avs_readdata <= {27'h000_0000, irqReq, irqVector};
                    default:
                        avs_readdata <= 32'h0000_0000;
                endcase
            end else begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end

endmodule

// [testbench/imfu_irq_props.sv]
`timescale 1ns/1ps
// port-level checks: bus handshake, read masking, request and global enable relations
module imfu_irq_props (
    // clock and reset
    input wire        ref_clk,
    input wire        reset_n,
    // register bus
    input wire [7:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    // core sequencer
    input wire        irqAck,
    input wire        returnFromIrq,
    input wire        globalSet,
    input wire        globalClear,
    input wire        irqReq,
    input wire [3:0]  irqVector,
    input wire        globalEnable
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // a request entered by the core; an ack with no request is ignored
    wire ackNow = irqAck && irqReq;

    a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered in one cycle");
    a_idle_zero: assert property (avs_waitrequest |-> avs_readdata == 32'h0000_0000)
        else $error("read data not zero outside the answer cycle");
    a_reserved_zero: assert property (!avs_waitrequest && avs_read |->
        avs_readdata[31:8] == 24'h00_0000 && (avs_address != 8'hE0 || !(|(avs_readdata[7:0] & 8'h35)))
        && (avs_address != 8'hE8 || avs_readdata[5:0] == 6'h00))
        else $error("reserved bits read as one");
    a_vector_range: assert property (irqReq |-> irqVector >= 4'h1 && irqVector <= 4'h6)
        else $error("request without a valid vector");
    a_gie_off_noreq: assert property (!globalEnable [*2] |-> !irqReq)
        else $error("request while global enable off");
    a_ack_clears_gie: assert property (ackNow && !globalSet |=> !globalEnable)
        else $error("global enable kept on handler entry");
    a_ack_drops_req: assert property (ackNow && !globalSet && !returnFromIrq |=> !irqReq)
        else $error("request kept after handler entry");
    a_return_sets_gie: assert property (
        (returnFromIrq || globalSet) && !ackNow && !globalClear |=> globalEnable)
        else $error("global enable not set on return");
    a_clear_drops_gie: assert property (globalClear && !globalSet && !returnFromIrq |=> !globalEnable)
        else $error("global enable not cleared");

    c_capture_taken: cover property (ackNow && irqVector == 4'h3);
    c_pin_a_taken: cover property (ackNow && irqVector == 4'h1);
    c_write_done: cover property (!avs_waitrequest && avs_write);
endmodule

bind imfu_irq_mask_flag_unit imfu_irq_props imfu_irq_props_inst (.*);

// [testbench/imfu_cpu_model.sv]
`timescale 1ns/1ps
// core sequencer: enters a handler ackDelay cycles after a request, returns 20 cycles later
module imfu_cpu_model (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // request side
    input  wire logic       irqReq,
    input  wire logic [3:0] irqVector,
    input  wire logic [7:0] ackDelay,
    // core answers
    output logic            irqAck,
    output logic            returnFromIrq
);
    logic [3:0] seen[$];
    // one handler at a time; a request that vanished during the delay is not entered
    initial begin
        irqAck = 1'b0;
        returnFromIrq = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (reset_n === 1'b1 && irqReq === 1'b1) begin
                repeat (ackDelay) @(posedge ref_clk);
                if (irqReq === 1'b1) begin
                    irqAck <= 1'b1; // entry clears the flag
                    @(posedge ref_clk);
                    seen.push_back(irqVector);
                    irqAck <= 1'b0;
                    repeat (20) @(posedge ref_clk);
                    returnFromIrq <= 1'b1; // re-enables interrupts
                    @(posedge ref_clk);
                    returnFromIrq <= 1'b0;
                end
            end
        end
    end
endmodule

// [testbench/imfu_irq_mask_flag_unit_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module imfu_irq_mask_flag_unit_tb;
    logic        ref_clk, reset_n, avs_read, avs_write, pinA, pinB, pwmMode;
    logic        avs_waitrequest, irqAck, returnFromIrq, irqReq, globalEnable;
    logic [7:0]  avs_address, ackDelay;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  irqVector;
    logic [6:0]  pls; // narrow, capture, match, turnaround, wide, set, clear
    logic [3:0]  expVec [6] = '{4'h3, 4'h4, 4'h5, 4'h1, 4'h2, 4'h1};
    int          err_total = 0, n_tests = 0, cycles = 0;

    imfu_irq_mask_flag_unit imfu_irq_mask_flag_unit_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pinA(pinA), .pinB(pinB), .wideOverflowEvt(pls[4]),
        .wideTurnaroundEvt(pls[3]), .pwmMode(pwmMode), .matchEvt(pls[2]), .captureEvt(pls[1]),
        .narrowOverflowEvt(pls[0]), .irqAck(irqAck), .returnFromIrq(returnFromIrq),
        .globalSet(pls[5]), .globalClear(pls[6]), .irqReq(irqReq), .irqVector(irqVector),
        .globalEnable(globalEnable));
    imfu_cpu_model imfu_cpu_model_inst (.ref_clk(ref_clk), .reset_n(reset_n), .irqReq(irqReq),
        .irqVector(irqVector), .ackDelay(ackDelay), .irqAck(irqAck),
        .returnFromIrq(returnFromIrq));

    // request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
        int n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) err_total++;
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        `CHK($sformatf("register %h", a), e, q)
    endtask
    // static on purpose: the index feeds a non-blocking assignment
    task pulse(input int i);
        @(posedge ref_clk);
        pls[i] <= 1'b1;
        @(posedge ref_clk);
        pls[i] <= 1'b0;
    endtask
    task automatic wait_vec(input int n);
        int k = 0;
        while (imfu_cpu_model_inst.seen.size() < n && k < 500) begin
            @(posedge ref_clk);
            k++;
        end
        `CHK("handler entries", n, imfu_cpu_model_inst.seen.size())
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // hang guard: the whole sequence needs well under 3000 cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    initial begin
        {reset_n, avs_read, avs_write, pwmMode, pls, ackDelay} = '0;
        {avs_address, avs_writedata} = '0;
        {pinA, pinB} = 2'b11; // both idle high, so default low-level sense stays quiet
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        foreach (expVec[i]) rd(8'hE0 + 8'(4 * (i % 5)), 8'h00);
        wr(8'h00, 8'hFF); // unmapped place ignores writes and reads zero
        rd(8'h00, 8'h00);
        wr(8'hE4, 8'hFF);
        rd(8'hE4, 8'hCA);
        wr(8'hEC, 8'hFF);
        rd(8'hEC, 8'hC0);
        // timer events latch while global enable is off
        for (int i = 0; i < 5; i++) if (i != 3) pulse(i);
        rd(8'hE0, 8'hCA);
        wr(8'hE0, 8'h02);
        rd(8'hE0, 8'hC8);
        wr(8'hE0, 8'h00);
        rd(8'hE0, 8'hC8);
        ackDelay <= 8'h03; // slow core
        pulse(5);
        wait_vec(3);
        repeat (30) @(posedge ref_clk);
        rd(8'hE0, 8'h00);
        // pwm mode: only the turnaround at zero sets the wide overflow flag
        pulse(6);
        pwmMode <= 1'b1;
        pulse(4);
        rd(8'hE0, 8'h00);
        pulse(3);
        rd(8'hE0, 8'h80);
        wr(8'hE0, 8'h80);
        pwmMode <= 1'b0;
        rd(8'hE0, 8'h00);
        // pin A falling edge, pin B rising edge
        ackDelay <= 8'h00; // prompt core
        wr(8'hF0, 8'h0E);
        pinA <= 1'b0;
        pinB <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rd(8'hE8, 8'h40);
        pinB <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rd(8'hE8, 8'hC0);
        pulse(5);
        wait_vec(5);
        repeat (30) @(posedge ref_clk);
        rd(8'hE8, 8'h00);
        // pin A low level, pin B reserved sense
        pulse(6);
        wr(8'hF0, 8'h04);
        rd(8'hF8, 8'h01);
        rd(8'hF4, 8'h00);
        pinB <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rd(8'hE8, 8'h00);
        pinB <= 1'b1;
        pulse(5);
        wait_vec(6);
        pinA <= 1'b1;
        repeat (40) @(posedge ref_clk);
        `CHK("handler entries", 6, imfu_cpu_model_inst.seen.size())
        foreach (expVec[i]) `CHK("vector", expVec[i], imfu_cpu_model_inst.seen[i])
        wrap_up();
    end
endmodule
